// [rtl/isb_top.sv]
// Local processor to system bus access control and status
`timescale 1ns/1ns
`include "isb_params.svh"
module isb_top
    import isb_pkg::*;
#(
    parameter int TMO_CYC = `ISB_TMO_CYC
) (
    input  wire logic        clk,       // 25 MHz clock
    input  wire logic        nrst,      // Async reset, low
    input  wire isb_lreq_t   lreq,      // Local access request
    output logic [7:0]       lp_rdata,  // Local read data
    output logic             lp_ack,    // Access done, pulse
    output logic             lp_wait,   // Hold local processor
    output isb_sbout_t       sb,        // System bus master side
    input  wire logic        sb_grant,  // Mastership granted
    input  wire logic        sb_reply,  // Slave reply
    input  wire logic [15:0] sb_din,    // Bus receiver data
    input  wire logic        sm_sel,    // Mailbox slave select
    input  wire logic        sm_wr,     // Mailbox write strobe
    input  wire logic        sm_idx,    // Mailbox number
    input  wire logic [15:0] sm_wdata,  // Mailbox write data
    output logic [15:0]      sm_rdata,  // Mailbox read data
    input  wire logic [1:0]  vec_iak,   // Interrupt grant seen
    output logic [1:0]       vec_pend,  // Vector interrupt pending
    output logic [7:0]       vec0_data, // Vector 0 contents
    output logic [7:0]       vec1_data, // Vector 1 contents
    input  wire logic        line_freq  // Mains square wave
);
    typedef struct packed {
        isb_state_t  st;
        logic        mb0;
        logic        mb1;
        logic        vb0;
        logic        vb1;
        logic        tmo;
        logic        byte_mode;
        logic [5:0]  ext;
        logic [7:0]  vec0;
        logic [7:0]  vec1;
        logic [7:0]  wlat;
        logic [15:0] rlat;
        isb_sbout_t  sb;
        logic        wr_op;
        logic        hi;
        logic        ack;
        logic [7:0]  rdata;
    } isb_top_state_t;

    isb_top_state_t q, d;
    isb_region_t    rg;
    logic           take;
    logic           expired;
    logic [7:0]     misc;

    isb_timeout #(
        .CYC     (TMO_CYC)
    ) u_tmo (
        .clk     (clk),
        .nrst    (nrst),
        .run     (q.st == ST_XFER),
        .expired (expired)
    );

    // Mailboxes sit on the system bus; the local side sees only their flags
    isb_mailbox #(
        .DEPTH (2),
        .W     (16)
    ) u_mbx (
        .clk   (clk),
        .nrst  (nrst),
        .wr_en (sm_sel && sm_wr),
        .idx   (sm_idx),
        .wdata (sm_wdata),
        .rdata (sm_rdata)
    );

    always_comb begin
        misc = 8'h00;
        misc[`ISB_B_MB0]  = q.mb0;
        misc[`ISB_B_MB1]  = q.mb1;
        misc[`ISB_B_VB0]  = q.vb0;
        misc[`ISB_B_VB1]  = q.vb1;
        misc[`ISB_B_LINE] = line_freq;
        misc[`ISB_B_TMO]  = q.tmo;
        misc[`ISB_B_MODE] = q.byte_mode;
    end

    assign rg   = isb_decode(lreq.addr);
    assign take = (q.st == ST_IDLE) && (lreq.rd || lreq.wr);

    always_comb begin
        d = q;
        d.ack = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (take && rg == RG_SYS) begin
                    if (!q.byte_mode && lreq.wr && !lreq.addr[0]) begin
                        d.wlat  = lreq.wdata;
                        d.ack   = 1'b1;
                        d.rdata = 8'h00;
                    end else if (!q.byte_mode && lreq.rd
                                 && lreq.addr[0]) begin
                        d.rdata = q.rlat[15:8];
                        d.ack   = 1'b1;
                    end else begin
                        d.st     = ST_REQ;
                        d.sb.req = 1'b1;
                        d.wr_op  = lreq.wr;
                        d.hi     = lreq.addr[0];
                        // Upper bits pick the bank
                        d.sb.addr = {q.ext, lreq.addr[15:1],
                                     q.byte_mode & lreq.addr[0]};
                        d.sb.bwtbt = q.byte_mode & lreq.wr;
                        // Word mode pairs the held low byte
                        d.sb.dout = q.byte_mode
                                  ? {lreq.wdata, lreq.wdata}
                                  : {lreq.wdata, q.wlat};
                    end
                end else if (take) begin
                    d.ack   = 1'b1;
                    d.rdata = 8'h00;
                    if (rg == RG_MISC && lreq.rd) begin
                        d.rdata = misc;
                    end else if (rg == RG_EXT && lreq.rd) begin
                        d.rdata = {2'b00, q.ext};
                    end else if (rg == RG_MISC) begin
                        // Flags only clear on a written zero
                        if (!lreq.wdata[`ISB_B_MB0]) d.mb0 = 1'b0;
                        if (!lreq.wdata[`ISB_B_MB1]) d.mb1 = 1'b0;
                        if (!lreq.wdata[`ISB_B_TMO]) d.tmo = 1'b0;
                        d.byte_mode = lreq.wdata[`ISB_B_MODE];
                    end else if (rg == RG_EXT) begin
                        d.ext = lreq.wdata[5:0];
                    end else if (rg == RG_VEC0) begin
                        d.vec0 = lreq.wdata;
                    end else if (rg == RG_VEC1) begin
                        d.vec1 = lreq.wdata;
                    end
                end
            end
            ST_REQ: begin
                if (sb_grant) begin
                    d.st          = ST_XFER;
                    d.sb.din_stb  = !q.wr_op;
                    d.sb.dout_stb = q.wr_op;
                    d.sb.dout_oe  = q.wr_op;
                end
            end
            ST_XFER: begin
                if (sb_reply || expired) begin
                    d.st          = ST_IDLE;
                    d.sb.req      = 1'b0;
                    d.sb.din_stb  = 1'b0;
                    d.sb.dout_stb = 1'b0;
                    d.sb.dout_oe  = 1'b0;
                    d.sb.bwtbt    = 1'b0;
                    d.ack         = 1'b1;
                    d.rdata       = 8'h00;
                    if (!sb_reply) begin
                        d.tmo   = 1'b1;
                        if (!q.wr_op) d.rdata = `ISB_TMO_DATA;
                    end else if (!q.wr_op) begin
                        d.rdata = q.hi ? sb_din[15:8] : sb_din[7:0];
                        if (!q.byte_mode) begin
                            d.rlat = sb_din;
                        end
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // Grant clears first so a same-cycle vector write still wins
        if (vec_iak[0]) d.vb0 = 1'b0;
        if (vec_iak[1]) d.vb1 = 1'b0;
        if (take && rg == RG_VEC0 && lreq.wr) d.vb0 = 1'b1;
        if (take && rg == RG_VEC1 && lreq.wr) d.vb1 = 1'b1;
        if (sm_sel && sm_wr && !sm_idx) d.mb0 = 1'b1;
        if (sm_sel && sm_wr && sm_idx) d.mb1 = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.byte_mode <= 1'(`ISB_MISC_RST >> `ISB_B_MODE);
            q.ext       <= `ISB_EXT_RST;
        end else begin
            q <= d;
        end
    end

    assign lp_rdata  = q.rdata;
    assign lp_ack    = q.ack;
    assign lp_wait   = (q.st != ST_IDLE);
    assign sb        = q.sb;
    assign vec_pend  = {q.vb1, q.vb0};
    assign vec0_data = q.vec0;
    assign vec1_data = q.vec1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_misc_read;
        take && rg == RG_MISC && lreq.rd
        |=> lp_ack && lp_rdata[`ISB_B_TMO] == $past(q.tmo)
            && lp_rdata[`ISB_B_MODE] == $past(q.byte_mode);
    endproperty
    a_misc_read: assert property (p_misc_read)
        else $error("status register read wrong");

    property p_line;
        take && rg == RG_MISC && lreq.rd
        |=> lp_rdata[`ISB_B_LINE] == $past(line_freq)
            && lp_rdata[5] == 1'b0;
    endproperty
    a_line: assert property (p_line)
        else $error("line frequency or unused bit wrong");

    property p_mb0;
        sm_sel && sm_wr && !sm_idx |=> q.mb0;
    endproperty
    a_mb0: assert property (p_mb0)
        else $error("mailbox 0 flag not set");

    property p_mb1;
        sm_sel && sm_wr && sm_idx |=> q.mb1;
    endproperty
    a_mb1: assert property (p_mb1)
        else $error("mailbox 1 flag not set");

    property p_vb0;
        take && rg == RG_VEC0 && lreq.wr |=> vec_pend[0] ##0 q.vec0 ==
            $past(lreq.wdata);
    endproperty
    a_vb0: assert property (p_vb0)
        else $error("vector 0 busy not set");

    property p_vb1_clr;
        vec_iak[1] && !(take && rg == RG_VEC1 && lreq.wr) |=> !vec_pend[1];
    endproperty
    a_vb1_clr: assert property (p_vb1_clr)
        else $error("vector 1 busy not cleared");

    property p_even_wr;
        take && rg == RG_SYS && !q.byte_mode && lreq.wr && !lreq.addr[0]
        |=> lp_ack && !sb.req && !lp_wait;
    endproperty
    a_even_wr: assert property (p_even_wr)
        else $error("even word write started a bus cycle");

    property p_odd_rd;
        take && rg == RG_SYS && !q.byte_mode && lreq.rd && lreq.addr[0]
        |=> lp_ack && !sb.req && lp_rdata == $past(q.rlat[15:8])
            && $stable(q.rlat);
    endproperty
    a_odd_rd: assert property (p_odd_rd)
        else $error("odd word read wrong");

    property p_tmo;
        q.st == ST_XFER && expired && !sb_reply
        |=> q.tmo && !sb.req && lp_ack ##1 !lp_ack;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout not flagged");

    property p_wait;
        sb.req || sb.din_stb || sb.dout_stb |-> lp_wait;
    endproperty
    a_wait: assert property (p_wait)
        else $error("processor released during bus cycle");

    property p_bw;
        sb.dout_stb |-> sb.bwtbt == q.byte_mode && sb.dout_oe;
    endproperty
    a_bw: assert property (p_bw)
        else $error("byte write signal wrong");
endmodule // isb_top

// [rtl/isb_params.svh]
// Constants for the system bus access control block
`ifndef ISB_PARAMS_SVH
`define ISB_PARAMS_SVH
`define ISB_CLK_MHZ    25
`define ISB_TMO_NS     10000
`define ISB_TMO_CYC    ((`ISB_TMO_NS * `ISB_CLK_MHZ) / 1000)
`define ISB_WIN_LOC    2'h0
`define ISB_WIN_SYS    2'h2
`define ISB_MISC_ADDR  16'h8040
`define ISB_EXT_ADDR   16'h8050
`define ISB_VEC1_ADDR  16'h808F
`define ISB_VEC0_ADDR  16'h80F0
`define ISB_B_MB0      0
`define ISB_B_MB1      1
`define ISB_B_VB0      2
`define ISB_B_VB1      3
`define ISB_B_LINE     4
`define ISB_B_TMO      6
`define ISB_B_MODE     7
`define ISB_MISC_RST   8'h00
`define ISB_EXT_RST    6'h00
`define ISB_TMO_DATA   8'hFF
`endif

// [rtl/isb_pkg.sv]
// Types and address decode for the system bus access control block
package isb_pkg;
`include "isb_params.svh"

    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER} isb_state_t;

    typedef enum logic [2:0] {
        RG_NONE, RG_MISC, RG_EXT, RG_VEC0, RG_VEC1, RG_SYS
    } isb_region_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } isb_lreq_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dout;
        logic        dout_oe;
        logic        din_stb;
        logic        dout_stb;
        logic        bwtbt;
        logic        req;
    } isb_sbout_t;

    function automatic isb_region_t isb_decode(input logic [19:0] a);
        if (a[19:18] == `ISB_WIN_SYS) return RG_SYS;
        else if (a[19:18] != `ISB_WIN_LOC) return RG_NONE;
        else if (a[15:0] == `ISB_MISC_ADDR) return RG_MISC;
        else if (a[15:0] == `ISB_EXT_ADDR) return RG_EXT;
        else if (a[15:0] == `ISB_VEC0_ADDR) return RG_VEC0;
        else if (a[15:0] == `ISB_VEC1_ADDR) return RG_VEC1;
        else return RG_NONE;
    endfunction
endpackage

// [rtl/isb_mailbox.sv]
// Mailbox word store with registered read data
`timescale 1ns/1ns
module isb_mailbox
    import isb_pkg::*;
#(
    parameter int DEPTH = 2,
    parameter int W     = 16
) (
    input  wire logic                     clk,   // System clock
    input  wire logic                     nrst,  // Async reset, low
    input  wire logic                     wr_en, // Write strobe
    input  wire logic [$clog2(DEPTH)-1:0] idx,   // Word select
    input  wire logic [W-1:0]             wdata, // Write data
    output logic      [W-1:0]             rdata  // Read data, registered
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } isb_mbx_state_t;

    isb_mbx_state_t q, d;

    always_comb begin
        d = q;
        d.rd = q.mem[idx];
        if (wr_en) begin
            d.mem[idx] = wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rd;
endmodule // isb_mailbox

// [rtl/isb_timeout.sv]
// Reply watchdog for local accesses to the system bus
`timescale 1ns/1ns
`include "isb_params.svh"
module isb_timeout
    import isb_pkg::*;
#(
    parameter int CYC = `ISB_TMO_CYC
) (
    input  wire logic clk,     // System clock
    input  wire logic nrst,    // Async reset, low
    input  wire logic run,     // Waiting for a reply
    output logic      expired  // Limit reached, level
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          exp;
    } isb_tmo_state_t;

    isb_tmo_state_t q, d;

    always_comb begin
        d = q;
        if (!run) begin
            d.cnt = '0;
            d.exp = 1'b0;
        end else if (q.cnt == CW'(CYC - 1)) begin
            d.exp = 1'b1;
        end else begin
            d.cnt = q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.exp;
endmodule // isb_timeout

// [testbench/isb_host_model.sv]
// Host processor and shared memory on the far side of the system bus
`timescale 1ns/1ns
module isb_host_model
    import isb_pkg::*;
(
    input  wire logic       clk,      // System clock
    input  wire logic       nrst,     // Async reset, low
    input  wire isb_sbout_t sb,       // Bus cycle from the block
    input  wire logic       quiet,    // Never reply, forces a timeout
    input  wire logic [3:0] slow,     // Extra reply delay in cycles
    output logic            sb_grant, // Mastership grant
    output logic            sb_reply, // Slave reply
    output logic [15:0]     sb_din    // Receiver data to the block
);
    logic [15:0] mem [16];
    logic [3:0]  cnt;
    logic [3:0]  wi;

    assign wi = sb.addr[4:1];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sb_grant <= 1'b0;
            sb_reply <= 1'b0;
            cnt      <= 4'h0;
            sb_din   <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 16'h0000;
            end
        end else begin
            sb_grant <= sb.req;
            if ((sb.din_stb || sb.dout_stb) && !quiet) begin
                if (cnt >= slow && !sb_reply) begin
                    sb_reply <= 1'b1;
                    if (sb.din_stb)
                        sb_din <= mem[wi];
                    else if (!sb.bwtbt)
                        mem[wi] <= sb.dout;
                    else if (sb.addr[0])
                        mem[wi][15:8] <= sb.dout[15:8];
                    else
                        mem[wi][7:0] <= sb.dout[7:0];
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                sb_reply <= 1'b0;
                cnt      <= 4'h0;
                // Released lines change each cycle so stale data is caught
                if (!sb.din_stb)
                    sb_din <= ~sb_din;
            end
        end
    end
endmodule // isb_host_model

// [testbench/tb.sv]
// Self-checking testbench for the system bus access control block
`timescale 1ns/1ns
module tb;
    import isb_pkg::*;
    typedef struct packed {
        logic        rd;
        logic [19:0] addr;
        logic [7:0]  wd;
        logic [7:0]  erd;
        logic        cyc;
        logic [15:0] ea;
        logic [15:0] dout;
        logic        bw;
    } isb_row_t;

    logic        clk, nrst, sb_grant, sb_reply, sm_sel, sm_wr, sm_idx;
    logic        lp_ack, lp_wait, line_freq, quiet, stb_q, last_bw;
    logic [7:0]  lp_rdata, vec0_data, vec1_data, rv;
    logic [15:0] sb_din, sm_wdata, sm_rdata, last_dout;
    logic [21:0] last_addr;
    logic [1:0]  vec_iak, vec_pend;
    logic [3:0]  slow;
    isb_lreq_t   lreq;
    isb_sbout_t  sb;
    int          mismatches, n_tests, ncyc, c0, lat, cycles;
    localparam logic [19:0] MISC = 20'h0_8040;
    isb_row_t rows [10] = '{
        '{1'b0, 20'h8_0004, 8'h34, 8'h00, 1'b0, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 20'h8_0005, 8'h12, 8'h00, 1'b1, 16'h0004, 16'h1234, 1'b0},
        '{1'b1, 20'h8_0004, 8'h00, 8'h34, 1'b1, 16'h0004, 16'h0000, 1'b0},
        '{1'b1, 20'h8_0005, 8'h00, 8'h12, 1'b0, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 20'h0_8040, 8'h80, 8'h00, 1'b0, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 20'h8_0007, 8'hAB, 8'h00, 1'b1, 16'h0007, 16'hABAB, 1'b1},
        '{1'b1, 20'h8_0007, 8'h00, 8'hAB, 1'b1, 16'h0007, 16'h0000, 1'b0},
        '{1'b1, 20'h8_0006, 8'h00, 8'h00, 1'b1, 16'h0006, 16'h0000, 1'b0},
        '{1'b1, 20'h0_8040, 8'h00, 8'h80, 1'b0, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 20'h0_8040, 8'h00, 8'h00, 1'b0, 16'h0000, 16'h0000, 1'b0}
    };

    isb_top #(.TMO_CYC(8)) DUT (.clk(clk), .nrst(nrst), .lreq(lreq),
        .lp_rdata(lp_rdata), .lp_ack(lp_ack), .lp_wait(lp_wait), .sb(sb),
        .sb_grant(sb_grant), .sb_reply(sb_reply), .sb_din(sb_din),
        .sm_sel(sm_sel), .sm_wr(sm_wr), .sm_idx(sm_idx),
        .sm_wdata(sm_wdata), .sm_rdata(sm_rdata), .vec_iak(vec_iak),
        .vec_pend(vec_pend), .vec0_data(vec0_data), .vec1_data(vec1_data),
        .line_freq(line_freq));

    isb_host_model host (.clk(clk), .nrst(nrst), .sb(sb), .quiet(quiet),
        .slow(slow), .sb_grant(sb_grant), .sb_reply(sb_reply),
        .sb_din(sb_din));

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Called at a falling edge; returns at the falling edge of the ack cycle
    task automatic acc(input logic rd, input logic [19:0] a,
                       input logic [7:0] wd, output logic [7:0] rdv);
        // One edge between requests so no strobe is set twice in a step
        @(negedge clk);
        lreq.addr  = a;
        lreq.wdata = wd;
        lreq.rd    = rd;
        lreq.wr    = !rd;
        lat        = 0;
        @(negedge clk);
        lreq.rd = 1'b0;
        lreq.wr = 1'b0;
        while (lp_ack !== 1'b1 && lat < 400) begin
            @(negedge clk);
            lat++;
        end
        chk("ack arrived", lat < 400, 1);
        rdv = lp_rdata;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk) begin
        if ((sb.din_stb | sb.dout_stb) && !stb_q) begin
            ncyc++;
            last_addr = sb.addr;
            last_dout = sb.dout;
            last_bw   = sb.bwtbt;
        end
        stb_q = sb.din_stb | sb.dout_stb;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test;
        end
    end

    initial begin
        nrst = 1'b0; lreq = '0; sm_sel = 1'b0; sm_wr = 1'b0; sm_idx = 1'b0;
        sm_wdata = 16'h0000; vec_iak = 2'b00; line_freq = 1'b0;
        quiet = 1'b0; slow = 4'h0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        chk("sb idle", sb, 0);
        chk("vec_pend", vec_pend, 0);
        acc(1'b1, MISC, 8'h00, rv);
        chk("status reset", rv, 8'h00);
        acc(1'b1, 20'h0_8041, 8'h00, rv);
        chk("near status", rv, 8'h00);
        foreach (rows[k]) begin
            c0 = ncyc;
            acc(rows[k].rd, rows[k].addr, rows[k].wd, rv);
            chk("row rdata", rv, rows[k].erd);
            chk("row cycles", ncyc - c0, rows[k].cyc);
            if (rows[k].cyc) begin
                chk("row addr", last_addr, {6'h00, rows[k].ea});
                chk("row byte write", last_bw, rows[k].bw);
                if (!rows[k].rd)
                    chk("row dout", last_dout, rows[k].dout);
            end
        end
        for (int i = 0; i < 2; i++) begin
            sm_sel = 1'b1; sm_wr = 1'b1; sm_idx = i[0];
            sm_wdata = 16'hBEE0 + 16'(i);
            @(negedge clk);
            sm_sel = 1'b0; sm_wr = 1'b0;
            @(negedge clk);
            chk("mailbox data", sm_rdata, 16'hBEE0 + i);
            acc(1'b1, MISC, 8'h00, rv);
            chk("mailbox flags", rv, i ? 8'h03 : 8'h01);
        end
        acc(1'b0, MISC, 8'h02, rv);
        acc(1'b1, MISC, 8'h00, rv);
        chk("clear flag 0", rv, 8'h02);
        acc(1'b0, MISC, 8'h7F, rv);
        acc(1'b1, MISC, 8'h00, rv);
        chk("read only bits", rv, 8'h02);
        acc(1'b0, MISC, 8'h00, rv);
        for (int i = 0; i < 2; i++) begin
            acc(1'b0, i ? 20'h0_808F : 20'h0_80F0, 8'h5A + 8'(i), rv);
            chk("vector busy", vec_pend, 2'b01 << i);
            chk("vector data", i ? vec1_data : vec0_data, 8'h5A + i);
            acc(1'b1, MISC, 8'h00, rv);
            // Line input was left high by the first pass
            chk("busy bit", rv,
                (8'h04 << i) | {3'b000, i[0], 4'h0});
            vec_iak = 2'b01 << i;
            @(negedge clk);
            vec_iak = 2'b00;
            @(negedge clk);
            chk("grant clears", vec_pend, 0);
            line_freq = i[0] ^ 1'b1;
            acc(1'b1, MISC, 8'h00, rv);
            chk("line bit", rv, {3'b000, ~i[0], 4'h0});
        end
        quiet = 1'b1;
        acc(1'b1, 20'h8_0010, 8'h00, rv);
        quiet = 1'b0;
        chk("timeout data", rv, 8'hFF);
        acc(1'b1, MISC, 8'h00, rv);
        chk("timeout flag", rv, 8'h40);
        acc(1'b0, MISC, 8'h00, rv);
        acc(1'b1, MISC, 8'h00, rv);
        chk("timeout cleared", rv, 8'h00);
        acc(1'b0, 20'h0_8050, 8'h2A, rv);
        acc(1'b1, 20'h0_8050, 8'h00, rv);
        chk("ext readback", rv, 8'h2A);
        slow = 4'h5;
        acc(1'b1, 20'h8_0004, 8'h00, rv);
        chk("slow reply wait", lat >= 6, 1);
        chk("bank bits", last_addr[21:16], 6'h2A);
        chk("bank read", rv, 8'h34);
        chk("wait released", lp_wait, 1'b0);
        slow = 4'h0;
        acc(1'b0, 20'h0_80F0, 8'h11, rv);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        chk("reset busy", vec_pend, 0);
        acc(1'b1, 20'h8_0005, 8'h00, rv);
        chk("read latch reset", rv, 8'h00);
        acc(1'b0, 20'h8_0005, 8'h77, rv);
        chk("write latch reset", last_dout, 16'h7700);
        finish_test;
    end
endmodule // tb
